// ### core/meas_pkg.sv
// Constants, register map and carrier types for the redundant and stack measurement controller
package meas_pkg;

    // Register word offsets (byte addresses)
    localparam logic [5:0] OFS_CONTROL = 6'h00;
    localparam logic [5:0] OFS_SELECT = 6'h04;
    localparam logic [5:0] OFS_PARTITION = 6'h08;
    localparam logic [5:0] OFS_HIGH = 6'h0C;
    localparam logic [5:0] OFS_LOW = 6'h10;
    localparam logic [5:0] OFS_STACK = 6'h14;
    localparam logic [5:0] OFS_STATUS = 6'h18;
    localparam logic [5:0] OFS_INTERVAL = 6'h1C;
    localparam logic [5:0] OFS_PLAUS = 6'h20;

    // Control register fields
    localparam int CTL_RED_START = 0;
    localparam int CTL_STACK_START = 1;
    localparam int CTL_PRIM_START = 2;
    localparam int CTL_RES_LO = 4;
    localparam int CTL_RES_W = 2;

    // Result field layout in the high and low registers
    localparam int RES_CODE_W = 11;
    localparam int RES_CNT_LO = 16;
    localparam int CNT_W = 2;
    localparam int STACK_W = 16;
    localparam int CELLS = 12;
    localparam int SUM_W = 20;

    // Reset values
    localparam logic [11:0] SELECT_RST = 12'h001;
    localparam logic [11:0] PARTITION_RST = 12'hFFF;
    localparam logic [15:0] INTERVAL_RST = 16'h0040;
    localparam logic [11:0] MARGIN_RST = 12'h000;

    // Stack resolution codes
    localparam logic [1:0] RES_10 = 2'h0;
    localparam logic [1:0] RES_14 = 2'h1;
    localparam logic [1:0] RES_15 = 2'h2;
    localparam logic [1:0] RES_16 = 2'h3;

    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int ADC_DIV = 64;
    localparam int CMP_WINDOW_LOG2 = 10;
    localparam int AVE_TIME_NS = 298000;
    localparam int AVE_CYCLES = (AVE_TIME_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int AVE_W = 13;
    localparam int PLAUS_MV = 78;

    typedef enum logic [1:0] {IDLE, SAMPLING, AVERAGING} red_state_e;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bus_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bus_rsp_s;

    typedef struct packed {
        red_state_e redState;
        logic [11:0] selectReg;
        logic [11:0] partitionReg;
        logic [1:0] stackRes;
        logic [15:0] intervalReg;
        logic [11:0] marginReg;
        logic [5:0] divCnt;
        logic [15:0] sampleCnt;
        logic [15:0] stackCnt;
        logic stackBusy;
        logic [AVE_W-1:0] aveCnt;
        logic [26:0] highAcc;
        logic [26:0] lowAcc;
        logic [10:0] highCode;
        logic [10:0] lowCode;
        logic [1:0] highUpd;
        logic [1:0] lowUpd;
        logic [15:0] stackCode;
        logic plausFail;
        logic cfgError;
        logic [9:0] cmpCnt;
        logic cmpTick;
        logic primStart;
        logic [31:0] readData;
        logic ack;
    } core_s;

endpackage

// ### core/redundant_stack_meas.sv
// Redundant cell and stack voltage measurement controller with Avalon-MM registers
`timescale 1ns/1ps
module redundant_stack_meas
    import meas_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire bus_req_s busReq,
    output bus_rsp_s busRsp,
    input wire logic adcTick,
    input wire logic [CELLS*RES_CODE_W-1:0] cellCodes,
    input wire logic [STACK_W-1:0] stackTopSample,
    output logic primStart,
    output logic stackActive,
    output logic cmpTick
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [10:0] cellAt(input logic [CELLS*RES_CODE_W-1:0] v, input int i);
        cellAt = v[i*RES_CODE_W +: RES_CODE_W];
    endfunction

    // Binary search: narrows each candidate one bit at a time against selected cells
    function automatic logic [10:0] searchExtreme(input logic [CELLS*RES_CODE_W-1:0] v,
                                                 input logic [11:0] sel, input logic findHigh);
        logic [10:0] guess;
        logic [10:0] trial;
        logic hit;
        guess = 11'h000;
        trial = 11'h000;
        hit = 1'b0;
        for (int b = RES_CODE_W - 1; b >= 0; b--) begin
            trial = guess | (11'h001 << b);
            hit = 1'b0;
            for (int c = 0; c < CELLS; c++) begin
                if (sel[c] && (findHigh ? (cellAt(v, c) >= trial) : (cellAt(v, c) < trial))) begin
                    hit = 1'b1;
                end
            end
            if (findHigh ? hit : !hit) begin
                guess = trial;
            end
        end
        searchExtreme = guess;
    endfunction

    function automatic logic [SUM_W-1:0] cellSum(input logic [CELLS*RES_CODE_W-1:0] v,
                                                input logic [11:0] act);
        logic [SUM_W-1:0] s;
        s = '0;
        for (int c = 0; c < CELLS; c++) begin
            if (act[c]) begin
                s = s + SUM_W'(cellAt(v, c));
            end
        end
        cellSum = s;
    endfunction

    function automatic logic [10:0] average(input logic [26:0] acc, input logic [15:0] n);
        logic [26:0] q;
        q = (n == 16'h0000) ? 27'h0000000 : acc / 27'(n);
        average = q[10:0];
    endfunction

    // Stack resolution mask keeps only the supported bit count
    function automatic logic [15:0] resMask(input logic [1:0] res);
        unique case (res)
            RES_10: resMask = 16'hFFC0;
            RES_14: resMask = 16'hFFFC;
            RES_15: resMask = 16'hFFFE;
            RES_16: resMask = 16'hFFFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers for pin-side data
    // ------------------------------------------------------------
    logic [STACK_W-1:0] stackMeta_q;
    logic [STACK_W-1:0] stackSync_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stackMeta_q <= '0;
            stackSync_q <= '0;
        end else begin
            stackMeta_q <= stackTopSample;
            stackSync_q <= stackMeta_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    core_s s_q;
    core_s s_d;

    logic isWrite;
    logic isRead;
    logic wrCommit;
    logic redLaunch;
    logic stackLaunch;
    logic [10:0] highNow;
    logic [10:0] lowNow;
    logic [SUM_W-1:0] sumNow;
    logic [SUM_W-1:0] stackScaled;
    logic [SUM_W-1:0] sumDiff;

    assign isWrite = busReq.write && !busReq.read;
    assign isRead = busReq.read && !busReq.write;
    // Writes and launches land on the completing edge, where waitrequest is low
    assign wrCommit = isWrite && s_q.ack;
    assign highNow = searchExtreme(cellCodes, s_q.selectReg & s_q.partitionReg, 1'b1);
    assign lowNow = searchExtreme(cellCodes, s_q.selectReg & s_q.partitionReg, 1'b0);
    assign sumNow = cellSum(cellCodes, s_q.partitionReg);
    // Compare at 11-bit cell scale: stack code top bits
    assign stackScaled = SUM_W'(s_q.stackCode[15:6]) << 4;
    assign sumDiff = (sumNow > stackScaled) ? (sumNow - stackScaled) : (stackScaled - sumNow);

    // refused if no usable cell selected
    assign redLaunch = wrCommit && (busReq.address == OFS_CONTROL) && busReq.writedata[CTL_RED_START]
                       && ((s_q.selectReg & s_q.partitionReg) != 12'h000) && (s_q.redState == IDLE);
    assign stackLaunch = wrCommit && (busReq.address == OFS_CONTROL) && busReq.writedata[CTL_STACK_START]
                         && !s_q.stackBusy;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.primStart = 1'b0;
        // comparator tick every 2^10 ADC samples
        s_d.cmpTick = 1'b0;

        if (adcTick) begin
            s_d.divCnt = s_q.divCnt + 6'h01;
            s_d.cmpCnt = s_q.cmpCnt + 10'h001;
            if (s_q.cmpCnt == 10'h3FF) begin
                s_d.cmpTick = 1'b1;
            end
        end

        // ---------------- Register bus ----------------
        if ((isWrite || isRead) && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.readData = 32'h00000000;
            if (isRead) begin
                unique case (busReq.address)
                    OFS_CONTROL: s_d.readData = {26'h0000000, s_q.stackRes, 4'h0};
                    OFS_SELECT: s_d.readData = {20'h00000, s_q.selectReg};
                    OFS_PARTITION: s_d.readData = {20'h00000, s_q.partitionReg};
                    OFS_HIGH: s_d.readData = {14'h0000, s_q.highUpd, 5'h00, s_q.highCode};
                    OFS_LOW: s_d.readData = {14'h0000, s_q.lowUpd, 5'h00, s_q.lowCode};
                    OFS_STACK: s_d.readData = {16'h0000, s_q.stackCode};
                    OFS_STATUS: s_d.readData = {27'h0000000, s_q.cfgError, s_q.plausFail,
                                                s_q.stackBusy, s_q.redState};
                    OFS_INTERVAL: s_d.readData = {16'h0000, s_q.intervalReg};
                    OFS_PLAUS: s_d.readData = {20'h00000, s_q.marginReg};
                    default: s_d.readData = 32'h00000000;
                endcase
            end
        end
        if (wrCommit) begin
            unique case (busReq.address)
                OFS_CONTROL: s_d.stackRes = busReq.writedata[CTL_RES_LO +: CTL_RES_W];
                OFS_SELECT: s_d.selectReg = busReq.writedata[11:0];
                OFS_PARTITION: s_d.partitionReg = busReq.writedata[11:0];
                OFS_INTERVAL: s_d.intervalReg = busReq.writedata[15:0];
                OFS_PLAUS: s_d.marginReg = busReq.writedata[11:0];
                default: ;
            endcase
        end

        // one primary start for all cells
        if (redLaunch || stackLaunch) begin
            s_d.primStart = 1'b1;
        end
        if (wrCommit && (busReq.address == OFS_CONTROL) && busReq.writedata[CTL_RED_START] && !redLaunch
            && (s_q.redState == IDLE)) begin
            s_d.cfgError = 1'b1;
        end

        // ---------------- Redundant measurement ----------------
        unique case (s_q.redState)
            IDLE: begin
                if (redLaunch) begin
                    s_d.redState = SAMPLING;
                    s_d.cfgError = 1'b0;
                    s_d.sampleCnt = 16'h0000;
                    s_d.highAcc = '0;
                    s_d.lowAcc = '0;
                    s_d.divCnt = 6'h00;
                end
            end
            SAMPLING: begin
                // one sample per 64 ADC ticks
                if (adcTick && (s_q.divCnt == 6'(ADC_DIV - 1))) begin
                    s_d.highAcc = s_q.highAcc + 27'(highNow);
                    s_d.lowAcc = s_q.lowAcc + 27'(lowNow);
                    s_d.sampleCnt = s_q.sampleCnt + 16'h0001;
                    if (s_q.sampleCnt + 16'h0001 >= s_q.intervalReg) begin
                        s_d.redState = AVERAGING;
                        s_d.aveCnt = '0;
                    end
                end
            end
            AVERAGING: begin
                if (s_q.aveCnt == AVE_W'(AVE_CYCLES - 1)) begin
                    s_d.redState = IDLE;
                    s_d.highCode = average(s_q.highAcc, s_q.sampleCnt);
                    s_d.lowCode = average(s_q.lowAcc, s_q.sampleCnt);
                    s_d.highUpd = s_q.highUpd + 2'h1;
                    s_d.lowUpd = s_q.lowUpd + 2'h1;
                end else begin
                    s_d.aveCnt = s_q.aveCnt + AVE_W'(1);
                end
            end
            default: s_d.redState = IDLE;
        endcase

        // ---------------- Stack measurement ----------------
        // stack window is the shared primary interval counted in ADC ticks
        if (stackLaunch) begin
            s_d.stackBusy = 1'b1;
            s_d.stackCnt = 16'h0000;
        end else if (s_q.stackBusy && adcTick) begin
            s_d.stackCnt = s_q.stackCnt + 16'h0001;
            if (s_q.stackCnt + 16'h0001 >= s_q.intervalReg) begin
                s_d.stackBusy = 1'b0;
                s_d.stackCode = stackSync_q & resMask(s_q.stackRes);
            end
        end

        // plausibility of cell sum against 10-bit stack
        if (!s_q.stackBusy && (s_q.stackRes == RES_10)) begin
            s_d.plausFail = (sumDiff > SUM_W'(s_q.marginReg));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{redState: IDLE, selectReg: SELECT_RST, partitionReg: PARTITION_RST,
                     intervalReg: INTERVAL_RST, marginReg: MARGIN_RST, stackRes: RES_16, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busRsp.waitrequest = (busReq.read || busReq.write) && !s_q.ack;
    assign busRsp.readdata = s_q.readData;
    assign primStart = s_q.primStart;
    assign stackActive = s_q.stackBusy;
    assign cmpTick = s_q.cmpTick;

endmodule

// ### sim/cell_stack_model.sv
// Battery stack model: cell codes, top-of-stack sense level and main ADC tick
`timescale 1ns/1ps
module cell_stack_model
    import meas_pkg::*;
#(
    parameter int TICK_DIV = 4
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [CELLS*RES_CODE_W-1:0] cellVolts,
    output logic adcTick,
    output logic [CELLS*RES_CODE_W-1:0] cellCodes,
    output logic [STACK_W-1:0] stackTopSample
);
    int divCnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 0;
            adcTick <= 1'b0;
        end else begin
            divCnt_q <= (divCnt_q == TICK_DIV - 1) ? 0 : divCnt_q + 1;
            adcTick <= (divCnt_q == TICK_DIV - 1);
        end
    end
    assign cellCodes = cellVolts;
    // top pin sees all twelve cells
    always_comb begin
        stackTopSample = 16'h0000;
        for (int c = 0; c < CELLS; c++) begin
            stackTopSample = stackTopSample + STACK_W'(cellVolts[c*RES_CODE_W +: RES_CODE_W]);
        end
    end
endmodule

// ### sim/redundant_stack_meas_sva.sv
// Checker for bus timing and measurement pulses of the measurement controller
`timescale 1ns/1ps
module redundant_stack_meas_sva
    import meas_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire bus_req_s busReq,
    input wire bus_rsp_s busRsp,
    input wire logic adcTick,
    input wire logic primStart,
    input wire logic stackActive,
    input wire logic cmpTick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [10:0] tickCnt_q;
    wire logic req = busReq.read | busReq.write;
    wire logic ctlWr = busReq.write && busReq.address == OFS_CONTROL;
    wire logic rdDone = busReq.read && !busRsp.waitrequest;
    // Ticks since the last comparator window closed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickCnt_q <= 11'h000;
        end else if (cmpTick) begin
            tickCnt_q <= {10'h000, adcTick};
        end else if (adcTick) begin
            tickCnt_q <= tickCnt_q + 11'h001;
        end
    end
    property p_wait_one;
        $rose(req) |-> busRsp.waitrequest ##1 !busRsp.waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("Bus answer not after one wait state");
    property p_idle_free;
        !req |-> !busRsp.waitrequest;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("Wait request without a request");
    property p_prim_pulse;
        primStart |=> !primStart;
    endproperty
    a_prim_pulse: assert property (p_prim_pulse) else $error("Primary start longer than one cycle");
    property p_prim_cause;
        primStart |-> ctlWr || $past(ctlWr) || $past(ctlWr, 2);
    endproperty
    a_prim_cause: assert property (p_prim_cause) else $error("Primary start without control write");
    property p_stack_cause;
        $rose(stackActive) |-> $past(ctlWr) || $past(ctlWr, 2);
    endproperty
    a_stack_cause: assert property (p_stack_cause) else $error("Stack run without control write");
    property p_ctl_selfclr;
        rdDone && busReq.address == OFS_CONTROL |-> busRsp.readdata[1:0] == 2'h0;
    endproperty
    a_ctl_selfclr: assert property (p_ctl_selfclr) else $error("Start field reads back set");
    property p_cmp_window;
        cmpTick |-> tickCnt_q inside {11'd1023, 11'd1024};
    endproperty
    a_cmp_window: assert property (p_cmp_window) else $error("Comparator window not 1024 ticks");
    property p_cmp_pulse;
        cmpTick |=> !cmpTick;
    endproperty
    a_cmp_pulse: assert property (p_cmp_pulse) else $error("Comparator tick longer than one cycle");
    c_prim: cover property (primStart);
    c_cmp: cover property (cmpTick);
    c_stack_end: cover property ($fell(stackActive));
endmodule

bind redundant_stack_meas redundant_stack_meas_sva i_redundant_stack_meas_sva (.ref_clk(ref_clk), .rst_n(rst_n),
    .busReq(busReq), .busRsp(busRsp), .adcTick(adcTick), .primStart(primStart), .stackActive(stackActive),
    .cmpTick(cmpTick));

// ### sim/redundant_stack_meas_tb_top.sv
// Self-checking bench for the redundant and stack measurement controller
`timescale 1ns/1ps
module redundant_stack_meas_tb_top import meas_pkg::*; ();
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
    } expect_s;
    localparam int RUN_CYC = 2 * ADC_DIV * 4 + AVE_CYCLES;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    bus_req_s busReq = '0;
    bus_rsp_s busRsp;
    logic adcTick;
    logic primStart;
    logic stackActive;
    logic cmpTick;
    logic [CELLS*RES_CODE_W-1:0] cellVolts = '0;
    logic [CELLS*RES_CODE_W-1:0] cellCodes;
    logic [STACK_W-1:0] stackTopSample;
    logic [31:0] rdData;
    expect_s expQ[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cycleCnt = 0;
    int seed = 24;

    always #20 ref_clk = ~ref_clk;

    redundant_stack_meas i_redundant_stack_meas (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
        .busRsp(busRsp), .adcTick(adcTick), .cellCodes(cellCodes), .stackTopSample(stackTopSample),
        .primStart(primStart), .stackActive(stackActive), .cmpTick(cmpTick));
    cell_stack_model #(.TICK_DIV(4)) i_cell_stack_model (.ref_clk(ref_clk), .rst_n(rst_n),
        .cellVolts(cellVolts), .adcTick(adcTick), .cellCodes(cellCodes), .stackTopSample(stackTopSample));

    // ----------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Request held until waitrequest is sampled low
    task automatic xfer(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
                        input logic [31:0] m);
        if (!w) expQ.push_back('{e, m});
        @(posedge ref_clk);
        busReq <= '{a, !w, w, d};
        // Ends on waitrequest sampled low; no guard besides the bench timeout
        do begin
            @(posedge ref_clk);
        end while (busRsp.waitrequest !== 1'b0);
        rdData = busRsp.readdata;
        busReq.read <= 1'b0;
        busReq.write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
        xfer(a, 1'b0, 32'h0, e, m);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 32'h0, 32'h0);
    endtask
    // Monitor: completed reads against the oldest note
    always @(posedge ref_clk) begin
        expect_s n;
        cycleCnt++;
        if (busReq.read === 1'b1 && busRsp.waitrequest === 1'b0 && expQ.size() > 0) begin
            n = expQ.pop_front();
            if (n.mask != 32'h0) check(((busRsp.readdata ^ n.data) & n.mask) === 32'h0, "read data");
        end
        if (cycleCnt == 40000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic red_run(input logic [11:0] sel, input logic [1:0] cnt);
        logic [10:0] hi;
        logic [10:0] lo;
        logic [10:0] v;
        int t0;
        int guard;
        @(posedge ref_clk);
        for (int c = 0; c < CELLS; c++) cellVolts[c*RES_CODE_W +: RES_CODE_W] <= 11'($random(seed));
        @(posedge ref_clk);
        hi = 11'h000;
        lo = 11'h7FF;
        for (int c = 0; c < CELLS; c++) begin
            v = cellVolts[c*RES_CODE_W +: RES_CODE_W];
            if (sel[c] && v > hi) hi = v;
            if (sel[c] && v < lo) lo = v;
        end
        wr(OFS_SELECT, {20'h0, sel});
        wr(OFS_PARTITION, {20'h0, sel | 12'($random(seed))});
        wr(OFS_CONTROL, 32'h33);
        t0 = cycleCnt;
        // Second start while sampling must be ignored
        wr(OFS_CONTROL, 32'h31);
        guard = 0;
        do begin
            rd(OFS_STATUS, 32'h0, 32'h0);
            guard++;
        end while (rdData[1:0] !== 2'h0 && guard < 4000);
        check(cycleCnt - t0 >= RUN_CYC - 12 && cycleCnt - t0 <= RUN_CYC + 24, "result time");
        rd(OFS_HIGH, {14'h0, cnt, 5'h0, hi}, 32'hFFFFFFFF);
        rd(OFS_LOW, {14'h0, cnt, 5'h0, lo}, 32'hFFFFFFFF);
    endtask

    initial begin
        logic [15:0] resMask [4];
        logic [15:0] sum;
        int guard;
        resMask = '{16'hFFC0, 16'hFFFC, 16'hFFFE, 16'hFFFF};
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFS_CONTROL, 32'h30, 32'hFFFFFFFF);
        rd(OFS_SELECT, 32'h001, 32'hFFFFFFFF);
        rd(OFS_PARTITION, 32'hFFF, 32'hFFFFFFFF);
        rd(OFS_INTERVAL, 32'h40, 32'hFFFFFFFF);
        rd(OFS_PLAUS, 32'h0, 32'hFFFFFFFF);
        rd(OFS_HIGH, 32'h0, 32'hFFFFFFFF);
        wr(6'h24, 32'hFFFFFFFF);
        rd(6'h24, 32'h0, 32'hFFFFFFFF);
        wr(OFS_INTERVAL, 32'h2);
        wr(OFS_PARTITION, 32'h0);
        wr(OFS_CONTROL, 32'h31);
        rd(OFS_STATUS, 32'h10, 32'h13);
        red_run(12'($random(seed)) | 12'h001, 2'h1);
        // Single selected cell: both results agree
        red_run(12'h001 << ($unsigned($random(seed)) % 12), 2'h2);
        sum = 16'h0000;
        for (int c = 0; c < CELLS; c++) sum = sum + 16'(cellVolts[c*RES_CODE_W +: RES_CODE_W]);
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CONTROL, 32'(r << 4) | 32'h2);
            // Launch registers on the completing edge, so busy shows one edge later
            @(posedge ref_clk);
            guard = 0;
            while (stackActive !== 1'b0 && guard < 100) begin
                @(posedge ref_clk);
                guard++;
            end
            check(guard >= 2 && guard <= 12, "stack window");
            rd(OFS_CONTROL, 32'(r << 4), 32'hFFFFFFFF);
            rd(OFS_STACK, {16'h0, sum}, {16'hFFFF, resMask[r]});
        end
        repeat (4) @(posedge ref_clk);
        final_report();
    end
endmodule
